//--- hw/serial_arbiter_bit_timer.sv
/*
 * Arbiter bit timer: bit time, break length and collision arbitration.
 * Assumes prescaler ticks and the internal transmit bit come from logic on
 * mclk; the receive pin is asynchronous.
 */
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module serial_arbiter_bit_timer
    import arbiter_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [1:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rd_data,
    input wire logic rxd_pin,
    input wire logic internal_tx_out,
    input wire logic bus_presc_tick,
    input wire logic xclk_presc_tick,
    output logic txd_pin
);
    typedef struct packed {
        logic [1:0] mode;
        logic aclk;
        logic lost;
        logic done;
        logic ovf;
        logic src_sel;
        logic [8:0] cnt;
        state_type state;
        logic [1:0] div;
        logic [2:0] rx_sync;
        logic rx_f;
        logic tx_prev;
        logic rx_low_seen;
        logic sampled;
        logic [1:0] echo_wait;
        logic [7:0] rd_data;
    } regs_type;

    regs_type r_q;
    regs_type r_d;

    logic ctrl_wr;
    logic presc_tick;
    logic tick;
    logic rx_fall;
    logic rx_rise;
    logic tx_rise;
    logic tx_fall;
    logic [8:0] sample_at;
    logic [7:0] ctrl_byte;
    logic rx_agree;
    logic arb_drop;
    logic lose_evt;

    assign ctrl_wr = wr_stb && (addr == ADDR_CTRL);
    assign presc_tick = r_q.src_sel ? xclk_presc_tick : bus_presc_tick;
    assign rx_agree = (r_q.rx_sync[1] == r_q.rx_sync[2]);
    assign rx_fall = r_q.rx_f && rx_agree && !r_q.rx_sync[2];
    assign rx_rise = !r_q.rx_f && rx_agree && r_q.rx_sync[2];
    assign tx_rise = internal_tx_out && !r_q.tx_prev;
    assign tx_fall = !internal_tx_out && r_q.tx_prev;
    assign sample_at = r_q.aclk ? ARB_SAMPLE_PRESC : ARB_SAMPLE_DIV;
    assign txd_pin = internal_tx_out | r_q.lost;
    assign arb_drop = tx_fall && !r_q.rx_low_seen && !r_q.sampled;
    // Lost sample this cycle; beats a clearing control write
    assign lose_evt = (r_q.mode == MODE_ARB) && (r_q.state == ST_RUN) && !tx_rise && !arb_drop &&
        tick && (r_q.cnt == sample_at) && !r_q.sampled && !r_q.rx_f;
    assign rd_data = r_q.rd_data;

    always_comb begin
        ctrl_byte = RESET_BYTE;
        ctrl_byte[BIT_MODE_HI] = r_q.mode[1];
        ctrl_byte[BIT_MODE_LO] = r_q.mode[0];
        ctrl_byte[BIT_LOST] = r_q.lost;
        ctrl_byte[BIT_ACLK] = r_q.aclk;
        ctrl_byte[BIT_DONE] = r_q.done;
        ctrl_byte[BIT_RUN] = (r_q.state == ST_RUN);
        ctrl_byte[BIT_OVF] = r_q.ovf;
        ctrl_byte[BIT_MSB] = r_q.cnt[8];
    end

    // Counter clock: every fourth clock or every fourth prescaler tick
    always_comb begin
        tick = 1'b0;
        if (r_q.aclk) begin
            tick = presc_tick && (r_q.div == DIV_LAST);
        end else begin
            tick = (r_q.div == DIV_LAST);
        end
    end

    always_comb begin
        r_d = r_q;
        // Three-stage receive synchroniser, accepted when the last two stages agree
        r_d.rx_sync = {r_q.rx_sync[1:0], rxd_pin};
        if (rx_agree) begin
            r_d.rx_f = r_q.rx_sync[2];
        end
        r_d.tx_prev = internal_tx_out;
        // Own echo lags the synchroniser after each transmitter rise
        if (r_q.echo_wait != 2'h0) begin
            r_d.echo_wait = r_q.echo_wait - 2'h1;
        end
        if (!r_q.aclk || presc_tick) begin
            r_d.div = r_q.div + 2'h1;
        end

        // Read data, valid the cycle after the strobe
        r_d.rd_data = RESET_BYTE;
        if (rd_stb) begin
            unique case (addr)
                ADDR_CTRL: r_d.rd_data = ctrl_byte;
                ADDR_COUNT_LOW: r_d.rd_data = r_q.cnt[7:0];
                ADDR_CONFIG: r_d.rd_data = {7'h00, r_q.src_sel};
                default: r_d.rd_data = RESET_BYTE;
            endcase
        end

        // Register writes
        if (wr_stb && (addr == ADDR_CONFIG)) begin
            r_d.src_sel = wr_data[BIT_SRC_SEL];
        end
        if (ctrl_wr) begin
            r_d.mode = {wr_data[BIT_MODE_HI], wr_data[BIT_MODE_LO]};
            r_d.aclk = wr_data[BIT_ACLK];
            r_d.done = 1'b0;
            r_d.ovf = 1'b0;
            r_d.cnt = 9'h000;
            r_d.div = 2'h0;
            r_d.sampled = 1'b0;
            r_d.rx_low_seen = 1'b0;
            if (lose_evt) begin
                r_d.lost = 1'b1;
            end else if (!wr_data[BIT_MODE_HI]) begin
                r_d.lost = 1'b0;
            end
            if ({wr_data[BIT_MODE_HI], wr_data[BIT_MODE_LO]} == MODE_MEASURE ||
                {wr_data[BIT_MODE_HI], wr_data[BIT_MODE_LO]} == MODE_ARB) begin
                r_d.state = ST_ARMED;
            end else begin
                r_d.state = ST_IDLE;
            end
        end else if (r_q.mode == MODE_MEASURE) begin
            unique case (r_q.state)
                ST_ARMED: begin
                    if (!r_q.aclk && rx_fall) begin
                        r_d.state = ST_RUN;
                        r_d.cnt = 9'h000;
                    end
                    if (r_q.aclk && !r_q.rx_f) begin
                        r_d.state = ST_RUN;
                        r_d.cnt = 9'h000;
                    end
                end
                ST_RUN: begin
                    if ((!r_q.aclk && rx_fall) || (r_q.aclk && rx_rise)) begin
                        r_d.state = ST_STOP;
                        r_d.done = 1'b1;
                    end else if (tick) begin
                        if (r_q.cnt == COUNT_MAX) begin
                            r_d.ovf = 1'b1;
                            r_d.cnt = 9'h000;
                            r_d.state = ST_STOP;
                        end else begin
                            r_d.cnt = r_q.cnt + 9'h001;
                        end
                    end
                end
                ST_IDLE, ST_STOP: r_d.state = r_q.state;
            endcase
        end else if (r_q.mode == MODE_ARB) begin
            unique case (r_q.state)
                ST_ARMED: begin
                    if (tx_rise) begin
                        r_d.state = ST_RUN;
                        r_d.cnt = 9'h000;
                        r_d.sampled = 1'b0;
                        r_d.rx_low_seen = 1'b0;
                        r_d.echo_wait = ECHO_HOLD;
                    end
                end
                ST_RUN: begin
                    if (!r_q.rx_f && (r_q.echo_wait == 2'h0)) begin
                        r_d.rx_low_seen = 1'b1;
                    end
                    if (tx_rise) begin
                        r_d.cnt = 9'h000;
                        r_d.sampled = 1'b0;
                        r_d.rx_low_seen = 1'b0;
                        r_d.echo_wait = ECHO_HOLD;
                    end else if (arb_drop) begin
                        r_d.cnt = 9'h000;
                        r_d.state = ST_ARMED;
                    end else if (tick) begin
                        if (r_q.cnt == sample_at && !r_q.sampled) begin
                            r_d.sampled = 1'b1;
                            if (!r_q.rx_f) begin
                                r_d.lost = 1'b1;
                            end
                        end
                        if (r_q.cnt == COUNT_MAX) begin
                            r_d.ovf = 1'b1;
                            r_d.cnt = 9'h000;
                            r_d.state = ST_ARMED;
                        end else begin
                            r_d.cnt = r_q.cnt + 9'h001;
                        end
                    end
                end
                ST_IDLE, ST_STOP: r_d.state = r_q.state;
            endcase
        end else begin
            r_d.cnt = 9'h000;
            r_d.state = ST_IDLE;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            r_q <= '{mode: 2'h0, aclk: 1'b0, lost: 1'b0, done: 1'b0, ovf: 1'b0,
                     src_sel: 1'b0, cnt: 9'h000, state: ST_IDLE, div: 2'h0,
                     rx_sync: 3'h7, rx_f: 1'b1, tx_prev: 1'b1, rx_low_seen: 1'b0,
                     sampled: 1'b0, echo_wait: 2'h0, rd_data: 8'h00};
        end else begin
            r_q <= r_d;
        end
    end
endmodule : serial_arbiter_bit_timer

//--- hw/arbiter_pkg.sv
/*
 * Constants, register map and types for the serial arbiter bit timer.
 * Assumes one 25 MHz clock and a plain strobe-based register port.
 */
package arbiter_pkg;
    // Register offsets
    localparam logic [1:0] ADDR_CTRL = 2'h0;
    localparam logic [1:0] ADDR_COUNT_LOW = 2'h1;
    localparam logic [1:0] ADDR_CONFIG = 2'h2;
    // Control/status and config bit positions
    localparam int BIT_MODE_HI = 7;
    localparam int BIT_MODE_LO = 6;
    localparam int BIT_LOST = 5;
    localparam int BIT_ACLK = 4;
    localparam int BIT_DONE = 3;
    localparam int BIT_RUN = 2;
    localparam int BIT_OVF = 1;
    localparam int BIT_MSB = 0;
    localparam int BIT_SRC_SEL = 0;
    // Modes
    localparam logic [1:0] MODE_IDLE = 2'h0;
    localparam logic [1:0] MODE_MEASURE = 2'h1;
    localparam logic [1:0] MODE_ARB = 2'h2;
    // Arbitration sample points, counter limit and divider end
    localparam logic [8:0] ARB_SAMPLE_DIV = 9'h038;
    localparam logic [8:0] ARB_SAMPLE_PRESC = 9'h008;
    localparam logic [8:0] COUNT_MAX = 9'h1ff;
    localparam logic [1:0] DIV_LAST = 2'h3;
    // Clocks that the own echo lags behind a transmitter rise
    localparam logic [1:0] ECHO_HOLD = 2'h3;
    // Reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ARMED = 2'b01,
        ST_RUN = 2'b10,
        ST_STOP = 2'b11
    } state_type;
endpackage : arbiter_pkg

//--- test/arb_timer_props.sv
/* Port checker for the arbiter bit timer.
   Assumes one clock mclk and asynchronous active-low reset rst_b. */
`timescale 1ns/1ps
module arb_timer_props (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [1:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] rd_data,
    input wire logic rxd_pin,
    input wire logic internal_tx_out,
    input wire logic bus_presc_tick,
    input wire logic xclk_presc_tick,
    input wire logic txd_pin
);
    logic ctl_wr;
    logic idle_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    assign ctl_wr = wr_stb && addr == 2'h0;
    // Last control write selected idle mode
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            idle_q <= 1'b1;
        end else if (ctl_wr) begin
            idle_q <= wr_data[7:6] == 2'h0;
        end
    end
    property p_tx_high; internal_tx_out |-> txd_pin; endproperty
    a_tx_high: assert property (p_tx_high)
        else $error("txd low while tx high");
    property p_lost_clr; ctl_wr && !wr_data[7] |=> txd_pin == internal_tx_out; endproperty
    a_lost_clr: assert property (p_lost_clr)
        else $error("lost not cleared by write");
    property p_flags_clr;
        ctl_wr ##1 (rd_stb && addr == 2'h0) |=> rd_data[3] == 1'b0 && rd_data[1:0] == 2'h0;
    endproperty
    a_flags_clr: assert property (p_flags_clr)
        else $error("flags not cleared by write");
    property p_mode_rw;
        ctl_wr ##1 (rd_stb && addr == 2'h0) |=>
            {rd_data[7:6], rd_data[4]} == {$past(wr_data[7:6], 2), $past(wr_data[4], 2)};
    endproperty
    a_mode_rw: assert property (p_mode_rw)
        else $error("mode bits readback wrong");
    property p_cnt_clr; ctl_wr ##1 (rd_stb && addr == 2'h1) |=> rd_data == 8'h00; endproperty
    a_cnt_clr: assert property (p_cnt_clr)
        else $error("count not cleared by write");
    property p_idle_cnt; idle_q && rd_stb && addr == 2'h1 |=> rd_data == 8'h00; endproperty
    a_idle_cnt: assert property (p_idle_cnt)
        else $error("count nonzero in idle");
    property p_idle_run;
        idle_q && rd_stb && addr == 2'h0 |=> rd_data[5] == 1'b0 && rd_data[2:0] == 3'h0;
    endproperty
    a_idle_run: assert property (p_idle_run)
        else $error("running in idle");
    property p_idle_tx; idle_q |-> txd_pin == internal_tx_out; endproperty
    a_idle_tx: assert property (p_idle_tx)
        else $error("txd forced in idle");
    c_lost: cover property (txd_pin && !internal_tx_out);
    c_done: cover property (rd_stb && addr == 2'h0 ##1 rd_data[3]);
    c_run: cover property (rd_stb && addr == 2'h0 ##1 rd_data[2]);
endmodule : arb_timer_props
bind serial_arbiter_bit_timer arb_timer_props chk (.mclk, .rst_b, .addr, .wr_data, .wr_stb,
    .rd_stb, .rd_data, .rxd_pin, .internal_tx_out, .bus_presc_tick, .xclk_presc_tick, .txd_pin);

//--- test/bus_node.sv
/* Another node on the shared serial line.
   Assumes a wired-AND line with pull-up; low is dominant. */
`timescale 1ns/1ps
module bus_node (
    input wire logic drive_low,
    input wire logic txd_pin,
    output logic rxd_pin
);
    // Either node pulls low, pull-up otherwise
    assign rxd_pin = txd_pin & ~drive_low;
endmodule : bus_node

//--- test/tb_top.sv
/* Self-checking bench for the arbiter bit timer.
   Assumes the bound port checker and the bus node model. */
`timescale 1ns/1ps
module tb_top;
    import arbiter_pkg::*;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wr_data = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic internal_tx_out = 1'b1;
    logic node_low = 1'b0;
    logic bus_presc_tick = 1'b0;
    logic xclk_presc_tick = 1'b0;
    logic [1:0] tick_cnt = 2'h0;
    logic [7:0] rd_data;
    logic [7:0] d;
    logic rxd_pin;
    logic txd_pin;
    int miscompares = 0;
    int samples_checked = 0;
    always #20 mclk = ~mclk;
    // Bus tick every 2 cycles, generator tick every 3
    always @(posedge mclk) begin
        tick_cnt <= (tick_cnt == 2'h2) ? 2'h0 : tick_cnt + 2'h1;
        bus_presc_tick <= ~bus_presc_tick;
        xclk_presc_tick <= tick_cnt == 2'h2;
    end
    serial_arbiter_bit_timer DUT (.mclk, .rst_b, .addr, .wr_data, .wr_stb, .rd_stb, .rd_data,
        .rxd_pin, .internal_tx_out, .bus_presc_tick, .xclk_presc_tick, .txd_pin);
    bus_node node (.drive_low(node_low), .txd_pin, .rxd_pin);
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        addr <= a;
        wr_data <= v;
        wr_stb <= 1'b1;
        rd_stb <= 1'b0;
        @(posedge mclk);
    endtask : wr
    task automatic rd(input logic [1:0] a);
        addr <= a;
        rd_stb <= 1'b1;
        wr_stb <= 1'b0;
        @(posedge mclk);
        rd_stb <= 1'b0;
        @(posedge mclk);
        d = rd_data;
    endtask : rd
    task automatic wait_cyc(input int n);
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        repeat (n) @(posedge mclk);
    endtask : wait_cyc
    task automatic t_regs;
        logic [7:0] v [4] = '{8'h50, 8'h90, 8'hd0, 8'h00};
        rd(2'h3);
        chk("unmapped", d, 8'h00);
        foreach (v[i]) begin
            wr(ADDR_CTRL, v[i]);
            rd(ADDR_CTRL);
            chk("mode_rw", d, v[i]);
        end
    endtask : t_regs
    task automatic t_bit_time;
        wr(ADDR_CTRL, 8'h40);
        node_low <= 1'b1;
        wait_cyc(20);
        node_low <= 1'b0;
        wait_cyc(20);
        rd(ADDR_CTRL);
        chk("run_mid", d, 8'h44);
        node_low <= 1'b1;
        wait_cyc(10);
        rd(ADDR_CTRL);
        chk("done", d, 8'h48);
        rd(ADDR_COUNT_LOW);
        chk("bit_len", 8'(d >= 8'h09 && d <= 8'h0b), 8'h01);
        wr(ADDR_CTRL, 8'h40);
        rd(ADDR_CTRL);
        chk("done_clr", d, 8'h40);
        node_low <= 1'b0;
    endtask : t_bit_time
    task automatic t_break;
        for (int s = 0; s < 2; s++) begin
            wr(ADDR_CONFIG, 8'(s));
            node_low <= 1'b1;
            wait_cyc(8);
            wr(ADDR_CTRL, 8'h50);
            wait_cyc(80 + 40 * s);
            rd(ADDR_CTRL);
            chk("brk_run", d, 8'h54);
            node_low <= 1'b0;
            wait_cyc(8);
            rd(ADDR_CTRL);
            chk("brk_done", d, 8'h58);
            rd(ADDR_COUNT_LOW);
            chk("brk_len", 8'(d >= 8'h09 && d <= 8'h0c), 8'h01);
        end
    endtask : t_break
    task automatic t_arb;
        wr(ADDR_CTRL, 8'h80);
        internal_tx_out <= 1'b0;
        wait_cyc(8);
        internal_tx_out <= 1'b1;
        node_low <= 1'b1;
        wait_cyc(240);
        internal_tx_out <= 1'b0;
        wait_cyc(2);
        chk("pin_forced", {7'h00, txd_pin}, 8'h01);
        rd(ADDR_CTRL);
        chk("lost", d & 8'he0, 8'ha0);
        wr(ADDR_CTRL, 8'h90);
        rd(ADDR_CTRL);
        chk("lost_kept", d & 8'he0, 8'ha0);
        wr(ADDR_CTRL, 8'h10);
        node_low <= 1'b0;
        rd(ADDR_CTRL);
        chk("lost_clr", d & 8'he0, 8'h00);
        chk("pin_free", {7'h00, txd_pin}, 8'h00);
        wr(ADDR_CTRL, 8'h90);
        internal_tx_out <= 1'b1;
        wait_cyc(40);
        rd(ADDR_COUNT_LOW);
        chk("arb_start", 8'(d != 8'h00), 8'h01);
        internal_tx_out <= 1'b0;
        wait_cyc(2);
        rd(ADDR_COUNT_LOW);
        chk("arb_reset", d, 8'h00);
        internal_tx_out <= 1'b1;
        wait_cyc(120);
        rd(ADDR_CTRL);
        chk("arb_win", d & 8'he0, 8'h80);
        wr(ADDR_CTRL, 8'h00);
    endtask : t_arb
    task automatic stop_test;
        $display("checks %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        stop_test();
    end
    initial begin
        wait_cyc(5);
        rst_b <= 1'b1;
        wait_cyc(1);
        t_regs();
        t_bit_time();
        t_break();
        t_arb();
        stop_test();
    end
endmodule : tb_top
